// ===== logic/msm_top.v
// Decided for this implementation: the register addresses and the APB interface to the registers.
`timescale 1ns/10ps
`default_nettype none
`include "msm_consts.vh"
module msm_top #(
    parameter AW = 8
) (
    input wire pclk,
    input wire presetn,
    input wire psel,
    input wire penable,
    input wire pwrite,
    input wire [AW-1:0] paddr,
    input wire [31:0] pwdata,
    output reg [31:0] prdata,
    output reg pready,
    output reg pslverr,
    input wire ee_probe_done,
    input wire ee_present,
    input wire [15:0] ee_signature,
    input wire fuse_all_zero,
    input wire ata_reset_line_in,
    input wire da2_in,
    input wire [1:0] cs_n_in,
    input wire drive_power_valid_in,
    input wire [1:0] da_in,
    input wire intrq_in,
    input wire bus_power_drive_enable_in,
    input wire dmarq_in,
    input wire iordy_in,
    input wire dmack_n_in,
    input wire dior_n_in,
    input wire diow_n_in,
    input wire [15:0] dd_in,
    output reg mode_ready_r,
    output reg legacy_pinout_r,
    output reg use_fuse_r,
    output reg eeprom_desc_r,
    output reg default_desc_r,
    output reg mfg_mode_r,
    output reg pin_override_r,
    output reg ata_reset_line_out,
    output reg [1:0] cs_n_out,
    output reg drive_power_valid_out,
    output reg [1:0] da_out,
    output reg dmack_n_out,
    output reg dior_n_out,
    output reg diow_n_out,
    output reg ctrl_oe,
    output reg [15:0] dd_out,
    output reg [15:0] dd_oe,
    output reg cfg_req_r,
    output reg cfg_read_r,
    output reg [31:0] cfg_len_r
);

    // Sequencer state codes.
    localparam [1:0] ST_PROBE = `MSM_ST_PROBE;
    localparam [1:0] ST_PINCFG = `MSM_ST_PINCFG;
    localparam [1:0] ST_STRAP = `MSM_ST_STRAP;
    localparam [1:0] ST_RUN = `MSM_ST_RUN;

    reg [1:0] state_r;
    reg [1:0] state_nxt;
    reg ee_found_r;
    reg ee_found_nxt;
    reg [15:0] sig_r;
    reg [15:0] sig_nxt;
    reg mode_ready_nxt;
    reg legacy_pinout_nxt;
    reg use_fuse_nxt;
    reg eeprom_desc_nxt;
    reg default_desc_nxt;
    reg mfg_mode_nxt;
    reg [7:0] desig_r;
    reg [31:0] len_r;
    reg [7:0] flags_r;
    reg [31:0] cb0_r;
    reg [31:0] cb1_r;
    reg [31:0] cb2_r;
    reg [31:0] cb3_r;
    reg [31:0] load_r;
    reg [31:0] snap_r;
    reg [3:0] cstat_r;

    wire access;
    wire wr;
    wire go;
    wire mapped;
    wire rest_zero;
    wire desig_ok;
    wire is_cfg;
    wire is_mfg;
    wire dir_in;
    wire [31:0] snap_now;
    wire test_on;
    wire pin_load;

    assign access = psel & penable & pready;
    assign wr = access & pwrite;
    assign go = wr && (paddr == `MSM_A_GO) && pwdata[0];
    assign mapped = (paddr[1:0] == 2'h0) && (paddr <= `MSM_A_CSTAT);

    assign dir_in = flags_r[`MSM_DIR_BIT];
    assign desig_ok = (cb0_r[7:0] == desig_r);
    // Reserved bytes 2 to 15 of a pin block must all be zero.
    assign rest_zero = (cb0_r[31:16] == 16'h0000) && (cb1_r == 32'h00000000) &&
                       (cb2_r == 32'h00000000) && (cb3_r == 32'h00000000);
    // configuration block; fixed fields are the host's duty but are checked.
    assign is_cfg = desig_ok && (cb0_r[15:8] == `MSM_SUB_CFG) && (cb0_r[23:16] == 8'h00) &&
                    (cb0_r[31:24] == `MSM_CFG_SRC) && (cb1_r == 32'h00000000) &&
                    (cb2_r == 32'h00000000) && (cb3_r == 32'h00000000);
    assign is_mfg = desig_ok && (cb0_r[15:8] == `MSM_SUB_MFG) && rest_zero;

    // Commands are refused until mode selection has ended, after which the mode flags no longer move.
    assign test_on = mode_ready_r & mfg_mode_r;
    assign pin_load = go & is_mfg & test_on & ~dir_in;

    // snapshot layout; status bits; byte 0 and data; strobes.
    assign snap_now = {dd_in[15:8], dd_in[7:0],
                       1'b0, mfg_mode_r, bus_power_drive_enable_in, dmarq_in,
                       iordy_in, dmack_n_in, dior_n_in, diow_n_in,
                       ata_reset_line_in, da2_in, cs_n_in, drive_power_valid_in,
                       da_in, intrq_in};

    always @* begin
        state_nxt = state_r;
        ee_found_nxt = ee_found_r;
        sig_nxt = sig_r;
        mode_ready_nxt = mode_ready_r;
        legacy_pinout_nxt = legacy_pinout_r;
        use_fuse_nxt = use_fuse_r;
        eeprom_desc_nxt = eeprom_desc_r;
        default_desc_nxt = default_desc_r;
        mfg_mode_nxt = mfg_mode_r;
        // Mode flags only rise here; only presetn lowers them.
        case (state_r)
            ST_PROBE: begin
                if (ee_probe_done) begin
                    ee_found_nxt = ee_present;
                    sig_nxt = ee_signature;
                    state_nxt = ST_PINCFG;
                end
            end
            ST_PINCFG: begin
                if (!ee_found_r) begin
                    use_fuse_nxt = ~fuse_all_zero;
                    if (fuse_all_zero) begin
                        default_desc_nxt = 1'b1;
                        mfg_mode_nxt = 1'b1;
                    end
                end else if (sig_r == `MSM_SIG_LEGACY) begin
                    legacy_pinout_nxt = 1'b1;
                    eeprom_desc_nxt = 1'b1;
                end else if (sig_r == `MSM_SIG_NORMAL) begin
                    eeprom_desc_nxt = 1'b1;
                end else begin
                    mfg_mode_nxt = 1'b1;
                end
                state_nxt = ST_STRAP;
            end
            ST_STRAP: begin
                if (!ata_reset_line_in) begin
                    mfg_mode_nxt = 1'b1;
                end
                mode_ready_nxt = 1'b1;
                state_nxt = ST_RUN;
            end
            ST_RUN: begin
                if (pin_load) begin
                    mfg_mode_nxt = 1'b1;
                end
            end
            default: begin
                state_nxt = ST_PROBE;
            end
        endcase
    end

    // The probe inputs are read once, so later noise on them cannot move the mode.
    always @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            state_r <= ST_PROBE;
            ee_found_r <= 1'b0;
            sig_r <= 16'h0000;
            mode_ready_r <= 1'b0;
            legacy_pinout_r <= 1'b0;
            use_fuse_r <= 1'b0;
            eeprom_desc_r <= 1'b0;
            default_desc_r <= 1'b0;
            mfg_mode_r <= 1'b0;
        end else begin
            state_r <= state_nxt;
            ee_found_r <= ee_found_nxt;
            sig_r <= sig_nxt;
            mode_ready_r <= mode_ready_nxt;
            legacy_pinout_r <= legacy_pinout_nxt;
            use_fuse_r <= use_fuse_nxt;
            eeprom_desc_r <= eeprom_desc_nxt;
            default_desc_r <= default_desc_nxt;
            mfg_mode_r <= mfg_mode_nxt;
        end
    end

    // Zero-wait APB slave: pready rises in the first access cycle.
    always @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            pready <= 1'b0;
            pslverr <= 1'b0;
            prdata <= 32'h00000000;
        end else begin
            pready <= psel & ~penable;
            // Unaligned or unmapped offsets answer with an error and read as zero.
            pslverr <= psel & ~penable & ~mapped;
            prdata <= 32'h00000000;
            if (psel && !penable && !pwrite) begin
                case (paddr)
                    `MSM_A_MODE: prdata <= {25'h0000000, mode_ready_r, pin_override_r, mfg_mode_r,
                                            default_desc_r, eeprom_desc_r, use_fuse_r, legacy_pinout_r};
                    `MSM_A_DESIG: prdata <= {24'h000000, desig_r};
                    `MSM_A_LEN: prdata <= len_r;
                    `MSM_A_FLAGS: prdata <= {24'h000000, flags_r};
                    `MSM_A_CB0: prdata <= cb0_r;
                    `MSM_A_CB1: prdata <= cb1_r;
                    `MSM_A_CB2: prdata <= cb2_r;
                    `MSM_A_CB3: prdata <= cb3_r;
                    `MSM_A_LOAD: prdata <= load_r;
                    `MSM_A_SNAP: prdata <= snap_r;
                    `MSM_A_CSTAT: prdata <= {28'h0000000, cstat_r};
                    default: prdata <= 32'h00000000;
                endcase
            end
        end
    end

    // Command block registers and decode.
    always @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            desig_r <= `MSM_DESIG_RST;
            len_r <= 32'h00000000;
            flags_r <= 8'h00;
            cb0_r <= 32'h00000000;
            cb1_r <= 32'h00000000;
            cb2_r <= 32'h00000000;
            cb3_r <= 32'h00000000;
            load_r <= 32'h00000000;
            snap_r <= 32'h00000000;
            cstat_r <= 4'h0;
            cfg_req_r <= 1'b0;
            cfg_read_r <= 1'b0;
            cfg_len_r <= 32'h00000000;
        end else begin
            cfg_req_r <= 1'b0;
            if (wr) begin
                case (paddr)
                    `MSM_A_DESIG: desig_r <= pwdata[7:0];
                    `MSM_A_LEN: len_r <= pwdata;
                    `MSM_A_FLAGS: flags_r <= pwdata[7:0];
                    `MSM_A_CB0: cb0_r <= pwdata;
                    `MSM_A_CB1: cb1_r <= pwdata;
                    `MSM_A_CB2: cb2_r <= pwdata;
                    `MSM_A_CB3: cb3_r <= pwdata;
                    `MSM_A_LOAD: load_r <= pwdata;
                    default: cstat_r <= cstat_r;
                endcase
            end
            if (go) begin
                // Vendor commands are only served in test mode.
                // test-mode gating
                // A rejected block changes nothing but the status word.
                if (!test_on || !(is_cfg || is_mfg)) begin
                    cstat_r <= 4'h8;
                end else if (is_cfg) begin
                    cfg_req_r <= 1'b1;
                    cfg_read_r <= dir_in;
                    cfg_len_r <= len_r;
                    // The engine still gets an oversize length; the flag lets software refuse it.
                    // oversize flagged, still forwarded
                    cstat_r <= {3'h0, 1'b1} | {1'b0, (len_r > 32'h000000ff), 2'h0};
                end else begin
                    cstat_r <= 4'h2;
                    if (dir_in) begin
                        snap_r <= snap_now;
                    end
                end
            end
        end
    end

    // pin load override; only the first four bytes matter.
    always @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            pin_override_r <= 1'b0;
            ata_reset_line_out <= 1'b1;
            cs_n_out <= 2'h3;
            drive_power_valid_out <= 1'b0;
            da_out <= 2'h0;
            dmack_n_out <= 1'b1;
            dior_n_out <= 1'b1;
            diow_n_out <= 1'b1;
            ctrl_oe <= 1'b0;
        end else if (pin_load) begin
            pin_override_r <= 1'b1;
            ctrl_oe <= 1'b1;
            // Load byte 0 bits 6 and 0 are input-only pins and are ignored.
            // byte 0 mapping
            ata_reset_line_out <= load_r[7];
            cs_n_out <= load_r[5:4];
            drive_power_valid_out <= load_r[3];
            da_out <= load_r[2:1];
            dmack_n_out <= load_r[10];
            dior_n_out <= load_r[9];
            diow_n_out <= load_r[8];
        end
    end

    // Data lines are one generate slice per bit so each enable is its own flop.
    genvar gi;
    generate
        for (gi = 0; gi < 16; gi = gi + 1) begin : g_dd
            always @(posedge pclk or negedge presetn) begin
                if (!presetn) begin
                    dd_out[gi] <= 1'b0;
                    dd_oe[gi] <= 1'b0;
                end else if (pin_load) begin
                    // All sixteen enables follow load byte 1 bit 7 together.
                    // data bus enable
                    dd_out[gi] <= load_r[16 + gi];
                    dd_oe[gi] <= load_r[15];
                end
            end
        end
    endgenerate

endmodule // msm_top
`default_nettype wire

// ===== logic/msm_consts.vh
`ifndef MSM_CONSTS_VH
`define MSM_CONSTS_VH
// Register byte addresses on the APB.
`define MSM_A_MODE 8'h00
`define MSM_A_DESIG 8'h04
`define MSM_A_LEN 8'h08
`define MSM_A_FLAGS 8'h0c
`define MSM_A_CB0 8'h10
`define MSM_A_CB1 8'h14
`define MSM_A_CB2 8'h18
`define MSM_A_CB3 8'h1c
`define MSM_A_GO 8'h20
`define MSM_A_LOAD 8'h24
`define MSM_A_SNAP 8'h28
`define MSM_A_CSTAT 8'h2c
// Recognised signature words.
`define MSM_SIG_LEGACY 16'h4d4d
`define MSM_SIG_NORMAL 16'h534b
// Subcommand codes and configuration block fixed fields.
`define MSM_SUB_CFG 8'h26
`define MSM_SUB_MFG 8'h27
`define MSM_CFG_SRC 8'h02
// Position of the direction flag in the CBW flag byte.
`define MSM_DIR_BIT 7
// Reset value of the command designator; arbitrary, software reloads it.
`define MSM_DESIG_RST 8'h24
// Power-up sequencer state codes.
`define MSM_ST_PROBE 2'h0
`define MSM_ST_PINCFG 2'h1
`define MSM_ST_STRAP 2'h2
`define MSM_ST_RUN 2'h3
`endif

// ===== sim/msm_assertions.sv
`timescale 1ns/10ps
`default_nettype none
module msm_chk (
    input wire logic pclk, presetn, psel, penable, pready, pslverr,
    input wire logic mode_ready_r, use_fuse_r, legacy_pinout_r, eeprom_desc_r, default_desc_r,
    input wire logic mfg_mode_r, pin_override_r, ctrl_oe, cfg_req_r,
    input wire logic [15:0] dd_oe
);
    default clocking cb @(posedge pclk); endclocking
    default disable iff (!presetn);
    property p_ready; mode_ready_r |=> mode_ready_r; endproperty
    a_ready: assert property (p_ready) else $error("mode ready dropped");
    property p_fuse; mode_ready_r && use_fuse_r |-> !eeprom_desc_r && !legacy_pinout_r; endproperty
    a_fuse: assert property (p_fuse) else $error("fuse mode mixed with eeprom mode");
    property p_dflt; default_desc_r |-> !use_fuse_r && mfg_mode_r; endproperty
    a_dflt: assert property (p_dflt) else $error("default descriptors outside blank fuse case");
    property p_mfg; mfg_mode_r |=> mfg_mode_r; endproperty
    a_mfg: assert property (p_mfg) else $error("test mode left without reset");
    property p_ovr; pin_override_r |-> mfg_mode_r && ctrl_oe ##1 pin_override_r; endproperty
    a_ovr: assert property (p_ovr) else $error("pin override inconsistent");
    property p_dd; dd_oe == 16'h0000 || dd_oe == 16'hffff; endproperty
    a_dd: assert property (p_dd) else $error("data line enables split");
    property p_cfg; cfg_req_r |-> mfg_mode_r ##1 !cfg_req_r; endproperty
    a_cfg: assert property (p_cfg) else $error("config request bad");
    property p_apb; psel && !penable |=> pready; endproperty
    a_apb: assert property (p_apb) else $error("bus answer late");
    property p_err; pslverr |-> pready; endproperty
    a_err: assert property (p_err) else $error("error without ready");
    c_mfg: cover property (mode_ready_r && mfg_mode_r);
    c_cfg: cover property (cfg_req_r);
    c_ovr: cover property ($rose(pin_override_r));
endmodule // msm_chk
bind msm_top msm_chk u_chk (.*);
`default_nettype wire

// ===== sim/msm_pins.sv
`timescale 1ns/10ps
`default_nettype none
module msm_pins (
    input wire logic pclk, presetn, mode_ready_r, p_present, p_fuse, p_strap,
    input wire logic [15:0] p_sig,
    input wire logic [31:0] pv,
    output logic ee_probe_done, ee_present, fuse_all_zero, ata_reset_line_in, da2_in, drive_power_valid_in,
    output logic intrq_in, bus_power_drive_enable_in, dmarq_in, iordy_in, dmack_n_in, dior_n_in, diow_n_in,
    output logic [1:0] cs_n_in, da_in,
    output logic [15:0] ee_signature, dd_in
);
    logic [1:0] cnt_r;
    always @(posedge pclk or negedge presetn) begin
        if (!presetn) cnt_r <= 2'h0;
        else if (cnt_r != 2'h3) cnt_r <= cnt_r + 2'h1;
    end
    assign ee_probe_done = cnt_r == 2'h3;
    assign ee_present = p_present;
    // The signature is garbage until the probe ends, so an early sample shows up.
    assign ee_signature = (ee_probe_done && p_present) ? p_sig : ~p_sig;
    assign fuse_all_zero = p_fuse;
    assign ata_reset_line_in = mode_ready_r ? pv[7] : p_strap;
    assign {da2_in, cs_n_in, drive_power_valid_in, da_in, intrq_in} = pv[6:0];
    assign {bus_power_drive_enable_in, dmarq_in, iordy_in, dmack_n_in, dior_n_in, diow_n_in} = pv[13:8];
    assign dd_in = pv[31:16];
endmodule // msm_pins
`default_nettype wire

// ===== sim/mode_select_and_mfg_test_tb_top.sv
`timescale 1ns/10ps
`default_nettype none
`include "msm_consts.vh"
module mode_select_and_mfg_test_tb_top;
    logic pclk = 0, presetn = 0, psel = 0, penable = 0, pwrite = 0, er, p_present = 0, p_fuse = 0, p_strap = 1;
    logic [7:0] paddr = 8'h00;
    logic [15:0] p_sig = 16'h0000;
    logic [31:0] pwdata = 32'h0, pv = 32'h0, rd, d, ln, seed = 32'h306f8aae;
    int n_mismatch = 0, comparisons = 0, n_req = 0;
    wire [31:0] prdata, cfg_len_r;
    wire [15:0] ee_signature, dd_in, dd_out, dd_oe;
    wire [1:0] cs_n_in, da_in, cs_n_out, da_out;
    wire pready, pslverr, ee_probe_done, ee_present, fuse_all_zero, ata_reset_line_in, da2_in;
    wire drive_power_valid_in, intrq_in, bus_power_drive_enable_in, dmarq_in, iordy_in, dmack_n_in, dior_n_in;
    wire diow_n_in, mode_ready_r, legacy_pinout_r, use_fuse_r, eeprom_desc_r, default_desc_r, mfg_mode_r;
    wire pin_override_r, ata_reset_line_out, drive_power_valid_out, dmack_n_out, dior_n_out, diow_n_out;
    wire ctrl_oe, cfg_req_r, cfg_read_r;
    msm_top DUT (.*);
    msm_pins u_pins (.*);
    always #25 pclk = ~pclk;
    // Counts accepted configuration requests, each a one-cycle pulse.
    always @(posedge pclk) begin
        if (cfg_req_r === 1'b1) n_req <= n_req + 1;
    end
    function automatic logic [31:0] lfsr(input logic [31:0] x);
        return {1'b0, x[31:1]} ^ (x[0] ? 32'h80200003 : 32'h0);
    endfunction
    task automatic chk(input logic [31:0] e, input logic [31:0] g);
        comparisons++;
        if (g !== e) begin
            n_mismatch++;
            $display("MISMATCH t=%0t exp=%h got=%h", $time, e, g);
        end
    endtask
    task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] dt);
        @(posedge pclk);
        psel <= 1; penable <= 0; pwrite <= w; paddr <= a; pwdata <= dt;
        @(posedge pclk);
        penable <= 1;
        do @(posedge pclk); while (pready !== 1'b1);
        rd = prdata; er = pslverr; psel <= 0; penable <= 0;
    endtask
    task automatic rst(input logic pp, input logic [15:0] s, input logic ff, input logic ss);
        logic em;
        em = !ss || (pp ? (s != `MSM_SIG_LEGACY && s != `MSM_SIG_NORMAL) : ff);
        p_present <= pp; p_sig <= s; p_fuse <= ff; p_strap <= ss; presetn <= 0;
        repeat (4) @(posedge pclk);
        presetn <= 1;
        do @(posedge pclk); while (mode_ready_r !== 1'b1);
        apb(0, `MSM_A_MODE, 0);
        chk({2'b10, em, !pp && ff, pp && (s == `MSM_SIG_NORMAL || s == `MSM_SIG_LEGACY), !pp && !ff,
             pp && s == `MSM_SIG_LEGACY}, rd[6:0]);
    endtask
    task automatic cmd(input logic [7:0] b0, b1, fl, input logic [31:0] l, ld, input logic [3:0] ecs);
        apb(1, `MSM_A_LOAD, ld);
        apb(1, `MSM_A_CB0, {(b1 == `MSM_SUB_CFG) ? `MSM_CFG_SRC : 8'h00, 8'h00, b1, b0});
        for (int i = 1; i < 4; i++) apb(1, 8'(`MSM_A_CB0 + 4 * i), 0);
        apb(1, `MSM_A_LEN, l);
        apb(1, `MSM_A_FLAGS, {24'h0, fl});
        apb(1, `MSM_A_GO, 1);
        apb(0, `MSM_A_CSTAT, 0);
        chk({28'h0, ecs}, rd);
    endtask
    task automatic summarize;
        $display("mismatches=%0d comparisons=%0d", n_mismatch, comparisons);
        if (n_mismatch == 0 && comparisons > 0) $display("== PASSED ==");
        else $display("== FAILED ==");
        $finish;
    endtask
    initial begin
        repeat (20000) @(posedge pclk);
        n_mismatch++;
        summarize;
    end
    initial begin
        rst(1, `MSM_SIG_NORMAL, 0, 1);
        cmd(`MSM_DESIG_RST, `MSM_SUB_MFG, 0, 4, 32'hffffffff, 4'h8);
        chk(0, pin_override_r);
        rst(0, 0, 1, 1);
        rst(0, 0, 0, 1);
        rst(1, `MSM_SIG_LEGACY, 0, 1);
        rst(1, seed[15:0] & 16'hfff0, 0, 1);
        rst(1, `MSM_SIG_NORMAL, 0, 0);
        apb(0, 8'h40, 0);
        chk(1, er);
        for (int i = 0; i < 2; i++) begin
            seed = lfsr(seed);
            d = {seed[31:16], i[0], seed[14:0]};
            cmd(`MSM_DESIG_RST, `MSM_SUB_MFG, 0, i ? {24'h0, seed[7:0]} : 4, d, 4'h2);
            chk({d[7], d[5:1]}, {ata_reset_line_out, cs_n_out, drive_power_valid_out, da_out});
            chk(d[10:8], {dmack_n_out, dior_n_out, diow_n_out});
            chk({{16{d[15]}}, d[31:16]}, {dd_oe, dd_out});
            chk(2'b11, {pin_override_r, ctrl_oe});
        end
        seed = lfsr(seed);
        pv <= seed;
        cmd(`MSM_DESIG_RST, `MSM_SUB_MFG, 8'h80, 4, 0, 4'h2);
        apb(0, `MSM_A_SNAP, 0);
        chk({seed[31:16], 2'b01, seed[13:0]}, rd);
        ln = (lfsr(seed) & 32'h000000fe) | 32'h00000001;
        cmd(`MSM_DESIG_RST, `MSM_SUB_CFG, 8'h80, ln, 0, 4'h1);
        chk({cfg_read_r, cfg_len_r}, {1'b1, ln});
        cmd(`MSM_DESIG_RST, `MSM_SUB_CFG, 8'h00, 300, 0, 4'h5);
        chk({cfg_read_r, cfg_len_r}, {1'b0, 32'd300});
        cmd(8'h25, `MSM_SUB_CFG, 8'h80, 4, 0, 4'h8);
        cmd(`MSM_DESIG_RST, 8'h33, 0, 4, 0, 4'h8);
        apb(1, `MSM_A_DESIG, 8'h5a);
        cmd(8'h5a, `MSM_SUB_MFG, 0, 4, 0, 4'h2);
        chk(2, n_req);
        summarize;
    end
endmodule // mode_select_and_mfg_test_tb_top
`default_nettype wire
